// File: shared/p0g_map.svh
// register offsets, reset values and timing counts of the port 0 block
`ifndef P0G_MAP_SVH
`define P0G_MAP_SVH

// ----------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------
`define P0G_ADDR_DATA 32'hfffff000
`define P0G_ADDR_DIR 32'hfffff020
`define P0G_ADDR_RISE 32'hfffff0c0
`define P0G_ADDR_FALL 32'hfffff0c2
`define P0G_ADDR_STAT 32'hfffff0c4
`define P0G_ADDR_MASK 32'hfffff0c6
`define P0G_ADDR_WID7 32'hfffff0c8

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define P0G_RST_DATA 8'h00
`define P0G_RST_DIR 8'hff
`define P0G_RST_EDGE 8'h00
`define P0G_RST_MASK 8'h00
`define P0G_RST_WID7 8'h02

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define P0G_BIT_NMI 0
`define P0G_BIT_TRIG 5
`define P0G_FIRST_DIG 5
`define P0G_PROG_PIN 7

// ----------------------------------------------------------------------
// timing: clock period and delay qualifier time in nanoseconds
// ----------------------------------------------------------------------
`define P0G_CLK_NS 50
`define P0G_QUAL_NS 100
`define P0G_QUAL_CYC ((`P0G_QUAL_NS + `P0G_CLK_NS - 1) / `P0G_CLK_NS)
`define P0G_DIG_CYC 2

`endif

// File: shared/p0g_pkg.sv
// types shared by the port 0 block
package p0g_pkg;

  // one port-wide byte
  typedef logic [7:0] p0g_byte_t;

  // register selected by the bus address
  typedef enum logic [2:0] {
    P0G_SEL_NONE,
    P0G_SEL_DATA,
    P0G_SEL_DIR,
    P0G_SEL_RISE,
    P0G_SEL_FALL,
    P0G_SEL_STAT,
    P0G_SEL_MASK,
    P0G_SEL_WID7
  } p0g_sel_t;

endpackage : p0g_pkg

// File: core/p0g_port.sv
// eight-bit port 0 with direction control, edge qualifiers and interrupts
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/10ps
`include "p0g_map.svh"

// ----------------------------------------------------------------------
// ----------------------------------------------------------------------

module p0g_port #(
  parameter int WIDTH = 8,
  parameter int CNT_W = 8
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic [31:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic bit_mode_i,
  input wire logic [2:0] bit_sel_i,
  output logic [7:0] rdata_o,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] pin_o,
  output logic [WIDTH-1:0] pin_oe_o,
  output logic nmi_o,
  output logic [6:0] ext_irq_o,
  output logic conv_trig_o,
  output logic irq_o
);

  // --------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------
  p0g_pkg::p0g_byte_t latch_q;
  p0g_pkg::p0g_byte_t dir_q;
  p0g_pkg::p0g_byte_t rise_q;
  p0g_pkg::p0g_byte_t fall_q;
  p0g_pkg::p0g_byte_t stat_q;
  p0g_pkg::p0g_byte_t mask_q;
  p0g_pkg::p0g_byte_t wid7_q;
  p0g_pkg::p0g_byte_t rdata_q;

  // input synchroniser stages
  logic [WIDTH-1:0] sync1_q;
  logic [WIDTH-1:0] sync2_q;
  logic [WIDTH-1:0] sync3_q;

  // qualified levels and their previous values
  logic [WIDTH-1:0] filt_q;
  logic [WIDTH-1:0] filt_prev_q;

  // edge events and pulse outputs
  logic [WIDTH-1:0] event_d;
  logic [WIDTH-1:0] event_q;

  // bus decode
  p0g_pkg::p0g_sel_t sel;
  p0g_pkg::p0g_byte_t wmask;
  p0g_pkg::p0g_byte_t rd_val;
  p0g_pkg::p0g_byte_t port_view;

  // --------------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------------

  // map the bus address onto a register selector
  always_comb
  begin
    unique case (addr_i)
      `P0G_ADDR_DATA: sel = p0g_pkg::P0G_SEL_DATA;
      `P0G_ADDR_DIR: sel = p0g_pkg::P0G_SEL_DIR;
      `P0G_ADDR_RISE: sel = p0g_pkg::P0G_SEL_RISE;
      `P0G_ADDR_FALL: sel = p0g_pkg::P0G_SEL_FALL;
      `P0G_ADDR_STAT: sel = p0g_pkg::P0G_SEL_STAT;
      `P0G_ADDR_MASK: sel = p0g_pkg::P0G_SEL_MASK;
      `P0G_ADDR_WID7: sel = p0g_pkg::P0G_SEL_WID7;
      default: sel = p0g_pkg::P0G_SEL_NONE;
    endcase
  end

  // byte access touches all bits, bit access only the selected one
  always_comb
  begin
    if (bit_mode_i)
    begin
      wmask = 8'h01 << bit_sel_i;
    end
    else
    begin
      wmask = 8'hff;
    end
  end

  // --------------------------------------------------------------------
  // port data and direction
  // --------------------------------------------------------------------

  // output latch; a write lands here whatever the direction
  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      latch_q <= `P0G_RST_DATA;
    end
    else if (wr_i && sel == p0g_pkg::P0G_SEL_DATA)
    begin
      latch_q <= (latch_q & ~wmask) | (wdata_i & wmask);
    end
  end

  // direction register, one bit per pin, 1 means input
  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      dir_q <= `P0G_RST_DIR;
    end
    else if (wr_i && sel == p0g_pkg::P0G_SEL_DIR)
    begin
      dir_q <= (dir_q & ~wmask) | (wdata_i & wmask);
    end
  end

  // drive the pins from the latch where the direction bit is clear
  always_comb
  begin
    pin_o = latch_q;
    pin_oe_o = ~dir_q;
  end

  // --------------------------------------------------------------------
  // input synchroniser
  // --------------------------------------------------------------------

  // three stages; only the second reads the first
  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end
    else
    begin
      sync1_q <= pin_i;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // unfiltered view for port reads: pin for inputs, latch for outputs
  always_comb
  begin
    port_view = (sync3_q & dir_q) | (latch_q & ~dir_q);
  end

  // --------------------------------------------------------------------
  // noise qualifiers, one per pin
  // --------------------------------------------------------------------

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1)
    begin : g_qual
      logic [CNT_W-1:0] cnt_q;
      logic [CNT_W-1:0] limit;
      logic agree;

      // a change counts only once stages two and three agree
      assign agree = (sync2_q[gi] == sync3_q[gi]);

      // pick the stable-time threshold for this pin's kind
      if (gi < `P0G_FIRST_DIG)
      begin : g_delay
        assign limit = CNT_W'(`P0G_QUAL_CYC);
      end
      else if (gi == `P0G_PROG_PIN)
      begin : g_prog
        assign limit = wid7_q[CNT_W-1:0];
      end
      else
      begin : g_digital
        assign limit = CNT_W'(`P0G_DIG_CYC);
      end

      // count cycles that a new level has stood, then accept it
      always_ff @(posedge sys_clk_i)
      begin
        if (!nrst_i)
        begin
          cnt_q <= '0;
          filt_q[gi] <= 1'b0;
        end
        else if (!agree || sync3_q[gi] == filt_q[gi])
        begin
          cnt_q <= '0; // a broken run is rejected
        end
        else if (cnt_q + 1'b1 >= limit)
        begin
          cnt_q <= '0;
          filt_q[gi] <= sync3_q[gi];
        end
        else
        begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  endgenerate

  // previous qualified level for edge detection
  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      filt_prev_q <= '0;
    end
    else
    begin
      filt_prev_q <= filt_q;
    end
  end

  // --------------------------------------------------------------------
  // edge selection
  // --------------------------------------------------------------------

  // rising edge selects, invalid after reset
  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      rise_q <= `P0G_RST_EDGE;
    end
    else if (wr_i && sel == p0g_pkg::P0G_SEL_RISE)
    begin
      rise_q <= (rise_q & ~wmask) | (wdata_i & wmask);
    end
  end

  // falling edge selects, invalid after reset
  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      fall_q <= `P0G_RST_EDGE;
    end
    else if (wr_i && sel == p0g_pkg::P0G_SEL_FALL)
    begin
      fall_q <= (fall_q & ~wmask) | (wdata_i & wmask);
    end
  end

  // filter width of the last interrupt input
  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      wid7_q <= `P0G_RST_WID7;
    end
    else if (wr_i && sel == p0g_pkg::P0G_SEL_WID7)
    begin
      wid7_q <= (wid7_q & ~wmask) | (wdata_i & wmask);
    end
  end

  // qualified edges gated by the selects; output pins are not
  // excluded, software must clear their selects or masks
  always_comb
  begin
    event_d = (filt_q & ~filt_prev_q & rise_q)
      | (~filt_q & filt_prev_q & fall_q);
  end

  // registered one-cycle event pulses
  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      event_q <= '0;
    end
    else
    begin
      event_q <= event_d;
    end
  end

  // route events to their request lines
  always_comb
  begin
    nmi_o = event_q[`P0G_BIT_NMI];
    ext_irq_o = event_q[WIDTH-1:1];
    conv_trig_o = event_q[`P0G_BIT_TRIG];
  end

  // --------------------------------------------------------------------
  // interrupt status and mask
  // --------------------------------------------------------------------

  // sticky status, write one to clear, a new event wins over the clear
  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      stat_q <= 8'h00;
    end
    else if (wr_i && sel == p0g_pkg::P0G_SEL_STAT)
    begin
      stat_q <= (stat_q & ~(wdata_i & wmask)) | event_q;
    end
    else
    begin
      stat_q <= stat_q | event_q;
    end
  end

  // mask: a one lets the status bit reach the interrupt line
  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      mask_q <= `P0G_RST_MASK;
    end
    else if (wr_i && sel == p0g_pkg::P0G_SEL_MASK)
    begin
      mask_q <= (mask_q & ~wmask) | (wdata_i & wmask);
    end
  end

  // level interrupt while any enabled status bit is set
  always_comb
  begin
    irq_o = |(stat_q & mask_q);
  end

  // --------------------------------------------------------------------
  // read path
  // --------------------------------------------------------------------

  // select the addressed register; unmapped reads return zero
  always_comb
  begin
    unique case (sel)
      p0g_pkg::P0G_SEL_DATA: rd_val = port_view;
      p0g_pkg::P0G_SEL_DIR: rd_val = dir_q;
      p0g_pkg::P0G_SEL_RISE: rd_val = rise_q;
      p0g_pkg::P0G_SEL_FALL: rd_val = fall_q;
      p0g_pkg::P0G_SEL_STAT: rd_val = stat_q;
      p0g_pkg::P0G_SEL_MASK: rd_val = mask_q;
      p0g_pkg::P0G_SEL_WID7: rd_val = wid7_q;
      p0g_pkg::P0G_SEL_NONE: rd_val = 8'h00;
    endcase
  end

  // read data register: valid the cycle after the strobe only
  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      rdata_q <= 8'h00;
    end
    else if (rd_i)
    begin
      rdata_q <= rd_val & wmask;
    end
    else
    begin
      rdata_q <= 8'h00;
    end
  end

  // read data output from its register
  always_comb
  begin
    rdata_o = rdata_q;
  end

endmodule : p0g_port

// File: testbench/p0g_port_chk.sv
// assertion checker for the port 0 block
`timescale 1ns/10ps
`include "p0g_map.svh"
module p0g_port_chk (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic [31:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic bit_mode_i,
  input wire logic [2:0] bit_sel_i,
  input wire logic [7:0] rdata_o,
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe_o,
  input wire logic nmi_o,
  input wire logic [6:0] ext_irq_o,
  input wire logic conv_trig_o
);
  logic armed_q;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!nrst_i);
  // --------
  // helper
  // --------
  // set once any edge select has been written since reset
  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
      armed_q <= 1'b0;
    else if (wr_i && (addr_i == `P0G_ADDR_RISE
                      || addr_i == `P0G_ADDR_FALL))
      armed_q <= 1'b1;
  end
  // --------
  // properties
  // --------
  property p_rst;
    $rose(nrst_i) |-> pin_oe_o == 8'h00 && pin_o == 8'h00;
  endproperty
  a_rst: assert property (p_rst)
    else $error("pins not released after reset");
  property p_dir;
    wr_i && !bit_mode_i && addr_i == `P0G_ADDR_DIR
      |=> pin_oe_o == ~$past(wdata_i);
  endproperty
  a_dir: assert property (p_dir)
    else $error("enable does not follow direction write");
  property p_dbit;
    wr_i && bit_mode_i && addr_i == `P0G_ADDR_DIR
      |=> pin_oe_o[$past(bit_sel_i)] != $past(wdata_i[bit_sel_i])
      && ((pin_oe_o ^ $past(pin_oe_o))
          & ~(8'h01 << $past(bit_sel_i))) == 8'h00;
  endproperty
  a_dbit: assert property (p_dbit)
    else $error("single bit direction write wrong");
  property p_lat;
    wr_i && !bit_mode_i && addr_i == `P0G_ADDR_DATA
      |=> pin_o == $past(wdata_i);
  endproperty
  a_lat: assert property (p_lat)
    else $error("latch not driven to pins");
  property p_rdo;
    rd_i && !bit_mode_i && addr_i == `P0G_ADDR_DATA
      |=> (rdata_o & $past(pin_oe_o)) == ($past(pin_o) & $past(pin_oe_o));
  endproperty
  a_rdo: assert property (p_rdo)
    else $error("output bits do not read the latch");
  property p_trig;
    conv_trig_o == ext_irq_o[4];
  endproperty
  a_trig: assert property (p_trig)
    else $error("trigger differs from pin 5 event");
  property p_pulse;
    nmi_o || ext_irq_o != 7'h00
      |=> ({ext_irq_o, nmi_o} & $past({ext_irq_o, nmi_o})) == 8'h00;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("event pulse longer than one cycle");
  property p_quiet;
    !armed_q |-> !nmi_o && ext_irq_o == 7'h00;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("event before any edge was selected");
  c_nmi: cover property (nmi_o);
  c_int6: cover property (ext_irq_o[6]);
  c_trig: cover property (conv_trig_o);
endmodule : p0g_port_chk

bind p0g_port p0g_port_chk i_p0g_port_chk (
  .sys_clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .bit_mode_i,
  .bit_sel_i, .rdata_o, .pin_o, .pin_oe_o, .nmi_o, .ext_irq_o,
  .conv_trig_o
);

// File: testbench/p0g_board.sv
// board model that meets the port 0 pins from outside
`timescale 1ns/10ps
module p0g_board (
  input wire logic [7:0] dev_out_i,
  input wire logic [7:0] dev_oe_i,
  input wire logic [7:0] ext_lvl_i,
  output logic [7:0] pin_lvl_o
);
  // device wins where it drives, board level elsewhere
  assign pin_lvl_o = (dev_oe_i & dev_out_i) | (~dev_oe_i & ext_lvl_i);
endmodule : p0g_board

// File: testbench/tb_top.sv
// self-checking bench of the port 0 block
`timescale 1ns/10ps
`include "p0g_map.svh"
module tb_top;
  logic sys_clk_i, nrst_i, wr_i, rd_i, bit_mode_i, nmi_o, conv_trig_o, irq_o;
  logic [2:0] bit_sel_i;
  logic [31:0] addr_i;
  logic [7:0] wdata_i, rdata_o, pin_i, pin_o, pin_oe_o, ext_lvl, rd_v;
  logic [6:0] ext_irq_o;
  int fail_count = 0;
  int samples_checked = 0;
  // --------
  // device and board
  // --------
  p0g_port i_p0g_port (
    .sys_clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .bit_mode_i,
    .bit_sel_i, .rdata_o, .pin_i, .pin_o, .pin_oe_o, .nmi_o, .ext_irq_o,
    .conv_trig_o, .irq_o
  );
  p0g_board i_p0g_board (.dev_out_i(pin_o), .dev_oe_i(pin_oe_o),
    .ext_lvl_i(ext_lvl), .pin_lvl_o(pin_i));
  // 50 ns clock
  initial
  begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  // --------
  // helpers
  // --------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize();
    if (fail_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask : cyc
  task automatic pins(input logic [7:0] v);
    @(posedge sys_clk_i);
    ext_lvl <= v;
  endtask : pins
  task automatic wr(input logic [31:0] a, input logic [7:0] d,
                    input logic bm = 1'b0, input logic [2:0] bs = 3'h0);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= d;
    bit_mode_i <= bm;
    bit_sel_i <= bs;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic bm = 1'b0,
                    input logic [2:0] bs = 3'h0);
    @(posedge sys_clk_i);
    addr_i <= a;
    bit_mode_i <= bm;
    bit_sel_i <= bs;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1 rd_v = rdata_o;
  endtask : rd
  // wait for the one-cycle event of pin k
  task automatic wait_ev(input int k);
    logic [7:0] ev;
    for (int n = 0; n < 30; n++)
    begin
      @(posedge sys_clk_i);
      #1 ev = {ext_irq_o, nmi_o};
      if (ev[k] === 1'b1)
        return;
    end
    chk({7'h00, ev[k]}, 8'h01);
    summarize();
  endtask : wait_ev
  // --------
  // scenarios
  // --------
  task automatic s_io();
    chk(pin_oe_o, 8'h00);
    rd(`P0G_ADDR_DIR);
    chk(rd_v, 8'hff);
    rd(32'hfffff010);
    chk(rd_v, 8'h00);
    wr(`P0G_ADDR_DATA, 8'h5a);
    chk(pin_oe_o, 8'h00);
    rd(`P0G_ADDR_DATA);
    chk(rd_v, 8'h00);
    wr(`P0G_ADDR_DIR, 8'h0f);
    wr(`P0G_ADDR_DATA, 8'ha5);
    chk(pin_oe_o, 8'hf0);
    chk(pin_o, 8'ha5);
    pins(8'h3c);
    cyc(5);
    rd(`P0G_ADDR_DATA);
    chk(rd_v, 8'hac);
  endtask : s_io
  task automatic s_bit();
    wr(`P0G_ADDR_DIR, 8'hff);
    wr(`P0G_ADDR_DIR, 8'h00, 1'b1, 3'h6);
    chk(pin_oe_o, 8'h40);
    rd(`P0G_ADDR_DIR, 1'b1, 3'h0);
    chk(rd_v, 8'h01);
    rd(`P0G_ADDR_DIR);
    chk(rd_v, 8'hbf);
    wr(`P0G_ADDR_DIR, 8'h40, 1'b1, 3'h6);
    chk(pin_oe_o, 8'h00);
  endtask : s_bit
  // pins toggle both ways while no edge is selected
  task automatic s_quiet();
    pins(8'hff);
    cyc(15);
    pins(8'h00);
    cyc(15);
    rd(`P0G_ADDR_STAT);
    chk(rd_v, 8'h00);
    chk({7'h00, irq_o}, 8'h00);
  endtask : s_quiet
  task automatic s_edge(input logic up);
    chk(pin_oe_o, 8'h00); // edges only selected on input pins
    wr(up ? `P0G_ADDR_RISE : `P0G_ADDR_FALL, 8'hff);
    for (int k = 0; k < 8; k++)
    begin
      @(posedge sys_clk_i);
      ext_lvl[k] <= up;
      wait_ev(k);
      chk({7'h00, conv_trig_o}, (k == 5) ? 8'h01 : 8'h00);
      rd(`P0G_ADDR_STAT);
      chk(rd_v, 8'h01 << k);
      // status lands one edge after the pulse, so look after the read
      chk({7'h00, irq_o}, 8'h01);
      wr(`P0G_ADDR_STAT, 8'h01 << k);
      chk({7'h00, irq_o}, 8'h00);
    end
    wr(up ? `P0G_ADDR_RISE : `P0G_ADDR_FALL, 8'h00);
  endtask : s_edge
  // short pulse dropped, masked event held in status
  task automatic s_glitch();
    wr(`P0G_ADDR_MASK, 8'h00);
    wr(`P0G_ADDR_RISE, 8'hff);
    pins(8'h40);
    pins(8'h00);
    cyc(15);
    rd(`P0G_ADDR_STAT);
    chk(rd_v, 8'h00);
    pins(8'h04);
    wait_ev(2);
    chk({7'h00, irq_o}, 8'h00);
    wr(`P0G_ADDR_MASK, 8'hff);
    chk({7'h00, irq_o}, 8'h01);
    wr(`P0G_ADDR_STAT, 8'h04);
    chk({7'h00, irq_o}, 8'h00);
    // widened filter on the last pin drops a four-cycle pulse
    wr(`P0G_ADDR_WID7, 8'h08);
    rd(`P0G_ADDR_WID7);
    chk(rd_v, 8'h08);
    pins(8'h80);
    cyc(3);
    pins(8'h00);
    cyc(15);
    rd(`P0G_ADDR_STAT);
    chk(rd_v, 8'h00);
    pins(8'h80);
    wait_ev(7);
    wr(`P0G_ADDR_STAT, 8'h80);
    chk({7'h00, irq_o}, 8'h00);
  endtask : s_glitch
  // --------
  // main sequence
  // --------
  initial
  begin
    nrst_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    bit_mode_i = 1'b0;
    bit_sel_i = 3'h0;
    addr_i = 32'h00000000;
    wdata_i = 8'h00;
    ext_lvl = 8'h00;
    repeat (20) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    #1;
    s_io();
    s_bit();
    s_quiet();
    wr(`P0G_ADDR_MASK, 8'hff);
    s_edge(1'b1);
    s_edge(1'b0);
    s_glitch();
    summarize();
  end
endmodule : tb_top
